// ### include/pfm_pkg.sv
package pfm_pkg;

  // Pad slots, in pad number order; the modes themselves decode in the top module.
  localparam int PAD_N    = 15;
  localparam int MODE_W   = 4;
  localparam int SLOT_P19 = 0;
  localparam int SLOT_P21 = 1;
  localparam int SLOT_P22 = 2;
  localparam int SLOT_P23 = 3;
  localparam int SLOT_P42 = 4;
  localparam int SLOT_P44 = 5;
  localparam int SLOT_P46 = 6;
  localparam int SLOT_P47 = 7;
  localparam int SLOT_P48 = 8;
  localparam int SLOT_P49 = 9;
  localparam int SLOT_P50 = 10;
  localparam int SLOT_P51 = 11;
  localparam int SLOT_P52 = 12;
  localparam int SLOT_P53 = 13;
  localparam int SLOT_P54 = 14;

  // Byte addresses of the mode-select registers, indexed by slot.
  localparam logic [31:0] PAD_OFS [PAD_N] = '{
    32'h4402E140, 32'h4402E110, 32'h4402E114, 32'h4402E104, 32'h4402E118,
    32'h4402E0A0, 32'h4402E0A4, 32'h4402E0A8, 32'h4402E0AC, 32'h4402E0B0,
    32'h4402E0B4, 32'h4402E0B8, 32'h4402E0BC, 32'h4402E0C0, 32'h4402E0C4};

  // Low-power pad configuration registers, and the pull enable, which applies in every state.
  localparam logic [31:0] OFS_SLEEP_OE   = 32'h4402E200;
  localparam logic [31:0] OFS_SLEEP_VAL  = 32'h4402E204;
  localparam logic [31:0] OFS_PULL_EN    = 32'h4402E208;

  // Mode reset values.
  localparam logic [MODE_W-1:0] MODE_DEBUG = 4'h1;
  localparam logic [MODE_W-1:0] MODE_OSC   = 4'hE;
  localparam logic [MODE_W-1:0] MODE_NONE  = 4'hF;
  localparam logic [MODE_W-1:0] MODE_RST [PAD_N] = '{
    MODE_NONE, MODE_DEBUG, MODE_DEBUG, MODE_OSC, MODE_NONE,
    MODE_NONE, MODE_NONE, MODE_NONE, MODE_NONE, MODE_NONE,
    MODE_NONE, MODE_NONE, MODE_NONE, MODE_NONE, MODE_NONE};
  localparam logic [PAD_N-1:0] PADS_RST = 15'h0000;

  typedef enum logic [5:0] {
    FN_NONE, FN_GPIO, FN_TCK, FN_TMS, FN_PWM2, FN_PWM3, FN_PWM5, FN_OSC,
    FN_U0TX, FN_U0RX, FN_U0CTS, FN_U0RTS, FN_U1TX, FN_U1RX, FN_U1CTS, FN_U1RTS,
    FN_ACLK, FN_AFS, FN_AD0, FN_AD1, FN_CAP0, FN_CAP1, FN_CAP2, FN_CAP5, FN_CAP6,
    FN_PCLK, FN_CD0, FN_CD1, FN_CD2, FN_CD3, FN_CIRQ, FN_SDD0, FN_SPICS, FN_SPIMISO
  } pfm_fn_t;

  // Signals the peripherals drive toward the pads.
  typedef struct packed {
    logic serial0_transmit;
    logic serial0_request_to_send_n;
    logic serial1_transmit;
    logic serial1_request_to_send_n;
    logic timer_pwm_out_2;
    logic timer_pwm_out_3;
    logic timer_pwm_out_5;
    logic audio_bit_clock;
    logic audio_frame_sync;
    logic audio_data_zero;
    logic audio_data_zero_oe;
    logic audio_data_one;
    logic audio_data_one_oe;
    logic card_data_line0;
    logic card_data_line0_oe;
    logic periph_serial_select;
    logic periph_serial_select_oe;
    logic periph_serial_in_line;
    logic periph_serial_in_line_oe;
    logic debug_mode_select;
    logic debug_mode_select_oe;
    logic oscillator_enable_out;
  } pfm_periph_out_t;

  // Signals the pads deliver to the peripherals.
  typedef struct packed {
    logic serial0_receive;
    logic serial0_clear_to_send_n;
    logic serial1_receive;
    logic serial1_clear_to_send_n;
    logic timer_capture_in_0;
    logic timer_capture_in_1;
    logic timer_capture_in_2;
    logic timer_capture_in_5;
    logic timer_capture_in_6;
    logic camera_pixel_clock;
    logic camera_data_bit0;
    logic camera_data_bit1;
    logic camera_data_bit2;
    logic camera_data_bit3;
    logic card_interrupt_in;
    logic card_data_line0;
    logic audio_data_zero;
    logic audio_data_one;
    logic periph_serial_select;
    logic periph_serial_in_line;
    logic debug_test_clock;
    logic debug_mode_select;
    logic power_on_sense_2;
  } pfm_periph_in_t;

endpackage

// ### src/pfm_pad_function_multiplexer.sv
// Operation
// - Pad 19 mode zero is general line 28.
// - Pad 21 resets to test clock; 8 PWM3.
// - Pad 22 resets to mode-select; 0 general 29.
// - Pad 23 oscillator enable, input is power_on_sense_2; low in hibernate and in mode E deep sleep; in mode 0 its drive enable follows i_general_oe while running.
// - Master reset low floats every pad.
// - Deep sleep holds transmit and request-to-send high.
// - Pad 44 mode table.
// - Pad 46 mode table.
// - Pad 47 mode table.
// - Pad 48 mode table.
// - Pad 49 mode table.
// - Pad 50 mode table.
// - Pad 51 mode table.
// - Pad 52 mode table.
// - Pad 53 mode table.
// - Pad 54 mode table.
// - Pad 42 mode table.
module pfm_pad_function_multiplexer (
  // Clock and reset
  input  wire logic                             i_sys_clk,
  input  wire logic                             i_reset_n,
  // Wishbone slave
  input  wire logic                             i_wb_cyc,
  input  wire logic                             i_wb_stb,
  input  wire logic                             i_wb_we,
  input  wire logic [31:0]                      i_wb_adr,
  input  wire logic [3:0]                       i_wb_sel,
  input  wire logic [31:0]                      i_wb_dat,
  output logic      [31:0]                      o_wb_dat,
  output logic                                  o_wb_ack,
  // Power state
  input  wire logic                             i_deep_sleep_state,
  input  wire logic                             i_hibernate_state,
  // General-purpose lines, one per pad slot
  input  wire logic [pfm_pkg::PAD_N-1:0]        i_general_out,
  input  wire logic [pfm_pkg::PAD_N-1:0]        i_general_oe,
  output logic      [pfm_pkg::PAD_N-1:0]        o_general_in,
  // Peripherals
  input  wire pfm_pkg::pfm_periph_out_t         i_periph,
  output pfm_pkg::pfm_periph_in_t               o_periph,
  // Pads
  input  wire logic [pfm_pkg::PAD_N-1:0]        i_pad_in,
  output logic      [pfm_pkg::PAD_N-1:0]        o_pad_out,
  output logic      [pfm_pkg::PAD_N-1:0]        o_pad_oe,
  output logic      [pfm_pkg::PAD_N-1:0]        o_pad_pull_en
);

  logic [pfm_pkg::MODE_W-1:0] mode_ff [pfm_pkg::PAD_N];
  logic [pfm_pkg::PAD_N-1:0]  sleep_oe_ff;
  logic [pfm_pkg::PAD_N-1:0]  sleep_val_ff;
  logic [pfm_pkg::PAD_N-1:0]  pull_en_ff;
  logic                       ack_ff;
  logic [31:0]                rdat_ff;
  logic [pfm_pkg::PAD_N-1:0]  pad_out_ff;
  logic [pfm_pkg::PAD_N-1:0]  pad_oe_ff;
  logic [pfm_pkg::PAD_N-1:0]  general_in_ff;
  pfm_pkg::pfm_periph_in_t    periph_ff;

  pfm_pkg::pfm_fn_t           fn_sel [pfm_pkg::PAD_N];
  logic [pfm_pkg::PAD_N-1:0]  nxt_pad_out;
  logic [pfm_pkg::PAD_N-1:0]  nxt_pad_oe;
  logic [pfm_pkg::PAD_N-1:0]  pad_hit;
  pfm_pkg::pfm_periph_in_t    nxt_periph;

  wire                        bus_req   = i_wb_cyc & i_wb_stb & ~ack_ff;
  wire                        bus_wr    = i_wb_cyc & i_wb_stb & i_wb_we & ack_ff;
  wire                        hit_soe   = (i_wb_adr == pfm_pkg::OFS_SLEEP_OE);
  wire                        hit_sval  = (i_wb_adr == pfm_pkg::OFS_SLEEP_VAL);
  wire                        hit_pull  = (i_wb_adr == pfm_pkg::OFS_PULL_EN);
  wire [pfm_pkg::PAD_N-1:0]   wr_mask   = {{7{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  // Mode decode per pad; anything not listed maps to no function.
  function automatic pfm_pkg::pfm_fn_t pad_fn(input int slot, input logic [3:0] m);
    pfm_pkg::pfm_fn_t f;
    f = pfm_pkg::FN_NONE;
    unique case (slot)
      pfm_pkg::SLOT_P19: begin
        if (m == 4'h0) f = pfm_pkg::FN_GPIO;
      end
      pfm_pkg::SLOT_P21: begin
        if (m == 4'h1) f = pfm_pkg::FN_TCK;
        else if (m == 4'h8) f = pfm_pkg::FN_PWM3;
      end
      pfm_pkg::SLOT_P22: begin
        if (m == 4'h1) f = pfm_pkg::FN_TMS;
        else if (m == 4'h0) f = pfm_pkg::FN_GPIO;
      end
      pfm_pkg::SLOT_P23: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'h9:    f = pfm_pkg::FN_PWM2;
          4'h2:    f = pfm_pkg::FN_AFS;
          4'hE:    f = pfm_pkg::FN_OSC;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      pfm_pkg::SLOT_P42: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'h9:    f = pfm_pkg::FN_U0TX;
          4'h2:    f = pfm_pkg::FN_ACLK;
          4'h3:    f = pfm_pkg::FN_AFS;
          4'h4:    f = pfm_pkg::FN_CAP5;
          4'h7:    f = pfm_pkg::FN_SPIMISO;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      pfm_pkg::SLOT_P44: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'hC:    f = pfm_pkg::FN_U0CTS;
          4'h6:    f = pfm_pkg::FN_AD1;
          4'h7:    f = pfm_pkg::FN_CAP0;
          4'h9:    f = pfm_pkg::FN_SPICS;
          4'hA:    f = pfm_pkg::FN_U1RTS;
          4'h3:    f = pfm_pkg::FN_U0RTS;
          4'h4:    f = pfm_pkg::FN_AD0;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      pfm_pkg::SLOT_P46: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'h3:    f = pfm_pkg::FN_U0TX;
          4'h4:    f = pfm_pkg::FN_PCLK;
          4'h6:    f = pfm_pkg::FN_U1TX;
          4'h7:    f = pfm_pkg::FN_CAP1;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      pfm_pkg::SLOT_P47: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'h3:    f = pfm_pkg::FN_U0RX;
          4'h6:    f = pfm_pkg::FN_U1RX;
          4'h7:    f = pfm_pkg::FN_CAP2;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      pfm_pkg::SLOT_P48: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'h6:    f = pfm_pkg::FN_U1TX;
          4'h4:    f = pfm_pkg::FN_CD3;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      pfm_pkg::SLOT_P49: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'h6:    f = pfm_pkg::FN_U1RX;
          4'h4:    f = pfm_pkg::FN_CD2;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      pfm_pkg::SLOT_P50: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'h4:    f = pfm_pkg::FN_CD1;
          4'h6:    f = pfm_pkg::FN_AD1;
          4'h7:    f = pfm_pkg::FN_CAP5;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      pfm_pkg::SLOT_P51: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'h5:    f = pfm_pkg::FN_U0RTS;
          4'h4:    f = pfm_pkg::FN_CD0;
          4'h3:    f = pfm_pkg::FN_U1CTS;
          4'h6:    f = pfm_pkg::FN_U0CTS;
          4'h7:    f = pfm_pkg::FN_CAP6;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      pfm_pkg::SLOT_P52: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'hD:    f = pfm_pkg::FN_ACLK;
          4'h3:    f = pfm_pkg::FN_U1RTS;
          4'hA:    f = pfm_pkg::FN_U0RTS;
          4'hB:    f = pfm_pkg::FN_U0TX;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      pfm_pkg::SLOT_P53: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'h6:    f = pfm_pkg::FN_CIRQ;
          4'h7:    f = pfm_pkg::FN_AFS;
          4'hC:    f = pfm_pkg::FN_CAP6;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
      default: begin
        unique case (m)
          4'h0:    f = pfm_pkg::FN_GPIO;
          4'h3:    f = pfm_pkg::FN_PWM5;
          4'h6:    f = pfm_pkg::FN_SDD0;
          4'h7:    f = pfm_pkg::FN_AD0;
          4'hC:    f = pfm_pkg::FN_CAP0;
          default: f = pfm_pkg::FN_NONE;
        endcase
      end
    endcase
    return f;
  endfunction

  // Serial outputs idle high; these get parked at 1 in deep sleep.
  function automatic logic is_serial_out(input pfm_pkg::pfm_fn_t f);
    return (f == pfm_pkg::FN_U0TX) || (f == pfm_pkg::FN_U0RTS) ||
           (f == pfm_pkg::FN_U1TX) || (f == pfm_pkg::FN_U1RTS);
  endfunction

  genvar gp;
  generate
    for (gp = 0; gp < pfm_pkg::PAD_N; gp++) begin : g_pad
      assign fn_sel[gp]  = pad_fn(gp, mode_ff[gp]);
      assign pad_hit[gp] = (i_wb_adr == pfm_pkg::PAD_OFS[gp]);

      always_comb begin
        logic o;
        logic e;
        o = 1'b0;
        e = 1'b0;
        unique case (fn_sel[gp])
          pfm_pkg::FN_GPIO:    begin o = i_general_out[gp]; e = i_general_oe[gp]; end
          pfm_pkg::FN_TMS:     begin o = i_periph.debug_mode_select; e = i_periph.debug_mode_select_oe; end
          pfm_pkg::FN_PWM2:    begin o = i_periph.timer_pwm_out_2; e = 1'b1; end
          pfm_pkg::FN_PWM3:    begin o = i_periph.timer_pwm_out_3; e = 1'b1; end
          pfm_pkg::FN_PWM5:    begin o = i_periph.timer_pwm_out_5; e = 1'b1; end
          pfm_pkg::FN_OSC:     begin o = i_periph.oscillator_enable_out; e = 1'b1; end
          pfm_pkg::FN_U0TX:    begin o = i_periph.serial0_transmit; e = 1'b1; end
          pfm_pkg::FN_U0RTS:   begin o = i_periph.serial0_request_to_send_n; e = 1'b1; end
          pfm_pkg::FN_U1TX:    begin o = i_periph.serial1_transmit; e = 1'b1; end
          pfm_pkg::FN_U1RTS:   begin o = i_periph.serial1_request_to_send_n; e = 1'b1; end
          pfm_pkg::FN_ACLK:    begin o = i_periph.audio_bit_clock; e = 1'b1; end
          pfm_pkg::FN_AFS:     begin o = i_periph.audio_frame_sync; e = 1'b1; end
          pfm_pkg::FN_AD0:     begin o = i_periph.audio_data_zero; e = i_periph.audio_data_zero_oe; end
          pfm_pkg::FN_AD1:     begin o = i_periph.audio_data_one; e = i_periph.audio_data_one_oe; end
          pfm_pkg::FN_SDD0:    begin o = i_periph.card_data_line0; e = i_periph.card_data_line0_oe; end
          pfm_pkg::FN_SPICS:   begin o = i_periph.periph_serial_select; e = i_periph.periph_serial_select_oe; end
          pfm_pkg::FN_SPIMISO: begin o = i_periph.periph_serial_in_line; e = i_periph.periph_serial_in_line_oe; end
          default:             begin o = 1'b0; e = 1'b0; end
        endcase
        // Hibernate wins over deep sleep; pad 23 must pull the oscillator low there.
        if (i_hibernate_state) begin
          if (gp == pfm_pkg::SLOT_P23) begin
            o = 1'b0;
            e = 1'b1;
          end else begin
            o = sleep_val_ff[gp];
            e = sleep_oe_ff[gp];
          end
        end else if (i_deep_sleep_state) begin
          if (is_serial_out(fn_sel[gp])) begin
            o = 1'b1;
            e = 1'b1;
          end else if (fn_sel[gp] == pfm_pkg::FN_OSC) begin
            o = 1'b0;
            e = 1'b1;
          end else if (fn_sel[gp] == pfm_pkg::FN_GPIO) begin
            o = sleep_val_ff[gp];
            e = sleep_oe_ff[gp];
          end
        end
        nxt_pad_out[gp] = o;
        nxt_pad_oe[gp]  = e;
      end
    end
  endgenerate

  // A pad input feeds a peripheral only while that pad selects it, except pad 23 to power_on_sense_2; idle levels cover the rest.
  function automatic logic route_in(input pfm_pkg::pfm_fn_t f, input logic idle);
    logic r;
    logic found;
    r = idle;
    found = 1'b0;
    for (int p = 0; p < pfm_pkg::PAD_N; p++) begin
      if (!found && fn_sel[p] == f) begin
        r = i_pad_in[p];
        found = 1'b1;
      end
    end
    return r;
  endfunction

  always_comb begin
    nxt_periph                         = '0;
    nxt_periph.serial0_receive         = route_in(pfm_pkg::FN_U0RX, 1'b1);
    nxt_periph.serial0_clear_to_send_n = route_in(pfm_pkg::FN_U0CTS, 1'b1);
    nxt_periph.serial1_receive         = route_in(pfm_pkg::FN_U1RX, 1'b1);
    nxt_periph.serial1_clear_to_send_n = route_in(pfm_pkg::FN_U1CTS, 1'b1);
    nxt_periph.timer_capture_in_0      = route_in(pfm_pkg::FN_CAP0, 1'b0);
    nxt_periph.timer_capture_in_1      = route_in(pfm_pkg::FN_CAP1, 1'b0);
    nxt_periph.timer_capture_in_2      = route_in(pfm_pkg::FN_CAP2, 1'b0);
    nxt_periph.timer_capture_in_5      = route_in(pfm_pkg::FN_CAP5, 1'b0);
    nxt_periph.timer_capture_in_6      = route_in(pfm_pkg::FN_CAP6, 1'b0);
    nxt_periph.camera_pixel_clock      = route_in(pfm_pkg::FN_PCLK, 1'b0);
    nxt_periph.camera_data_bit0        = route_in(pfm_pkg::FN_CD0, 1'b0);
    nxt_periph.camera_data_bit1        = route_in(pfm_pkg::FN_CD1, 1'b0);
    nxt_periph.camera_data_bit2        = route_in(pfm_pkg::FN_CD2, 1'b0);
    nxt_periph.camera_data_bit3        = route_in(pfm_pkg::FN_CD3, 1'b0);
    nxt_periph.card_interrupt_in       = route_in(pfm_pkg::FN_CIRQ, 1'b0);
    nxt_periph.card_data_line0         = route_in(pfm_pkg::FN_SDD0, 1'b1);
    nxt_periph.audio_data_zero         = route_in(pfm_pkg::FN_AD0, 1'b0);
    nxt_periph.audio_data_one          = route_in(pfm_pkg::FN_AD1, 1'b0);
    nxt_periph.periph_serial_select    = route_in(pfm_pkg::FN_SPICS, 1'b1);
    nxt_periph.periph_serial_in_line   = route_in(pfm_pkg::FN_SPIMISO, 1'b0);
    nxt_periph.debug_test_clock        = route_in(pfm_pkg::FN_TCK, 1'b0);
    nxt_periph.debug_mode_select       = route_in(pfm_pkg::FN_TMS, 1'b1);
    nxt_periph.power_on_sense_2        = i_pad_in[pfm_pkg::SLOT_P23];
  end

  // Read mux; unmapped addresses read zero and still acknowledge.
  logic [31:0] nxt_rdat;
  always_comb begin
    nxt_rdat = '0;
    for (int p = 0; p < pfm_pkg::PAD_N; p++) begin
      if (pad_hit[p]) nxt_rdat[pfm_pkg::MODE_W-1:0] = mode_ff[p];
    end
    if (hit_soe)  nxt_rdat[pfm_pkg::PAD_N-1:0] = sleep_oe_ff;
    if (hit_sval) nxt_rdat[pfm_pkg::PAD_N-1:0] = sleep_val_ff;
    if (hit_pull) nxt_rdat[pfm_pkg::PAD_N-1:0] = pull_en_ff;
  end

  // Mode registers come up at their defaults so the debug port works out of reset.
  generate
    for (gp = 0; gp < pfm_pkg::PAD_N; gp++) begin : g_mode
      always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          mode_ff[gp] <= pfm_pkg::MODE_RST[gp];
        end else if (bus_wr && pad_hit[gp] && i_wb_sel[0]) begin
          mode_ff[gp] <= i_wb_dat[pfm_pkg::MODE_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sleep_oe_ff  <= pfm_pkg::PADS_RST;
      sleep_val_ff <= pfm_pkg::PADS_RST;
      pull_en_ff   <= pfm_pkg::PADS_RST;
    end else begin
      if (bus_wr && hit_soe)
        sleep_oe_ff <= (sleep_oe_ff & ~wr_mask) | (i_wb_dat[pfm_pkg::PAD_N-1:0] & wr_mask);
      if (bus_wr && hit_sval)
        sleep_val_ff <= (sleep_val_ff & ~wr_mask) | (i_wb_dat[pfm_pkg::PAD_N-1:0] & wr_mask);
      if (bus_wr && hit_pull)
        pull_en_ff <= (pull_en_ff & ~wr_mask) | (i_wb_dat[pfm_pkg::PAD_N-1:0] & wr_mask);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_ff  <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff  <= bus_req;
      rdat_ff <= bus_req ? nxt_rdat : '0;
    end
  end

  // Everything facing pads and peripherals is registered; reset floats every pad.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pad_out_ff    <= '0;
      pad_oe_ff     <= '0;
      general_in_ff <= '0;
      periph_ff     <= '0;
    end else begin
      pad_out_ff    <= nxt_pad_out;
      pad_oe_ff     <= nxt_pad_oe;
      general_in_ff <= i_pad_in;
      periph_ff     <= nxt_periph;
    end
  end

  assign o_wb_ack      = ack_ff;
  assign o_wb_dat      = rdat_ff;
  assign o_pad_out     = pad_out_ff;
  assign o_pad_oe      = pad_oe_ff;
  assign o_pad_pull_en = pull_en_ff;
  assign o_general_in  = general_in_ff;
  assign o_periph      = periph_ff;

endmodule

// ### testbench/pad_function_multiplexer_tb_top.sv
module pad_function_multiplexer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clk = 0, rst_n = 1, cyc = 0, stb = 0, we = 0, deep = 0, hib = 0, ack;
  logic [31:0]               adr = '0, wdat = '0, rdat, q, sv, vv;
  logic [14:0]               gout = '0, goe = '0, gin, pin, pout, poe, pull, ext = '0, ext_en = '1;
  pfm_pkg::pfm_periph_out_t  per = '0;
  pfm_pkg::pfm_periph_in_t   pio;
  int                        errors = 0, n_checks = 0;
  logic [7:0] tab [20] = '{8'h00, 8'h20, 8'h18, 8'h39, 8'h32, 8'h49, 8'h42, 8'h5A, 8'h53, 8'h63,
    8'h66, 8'h86, 8'hB5, 8'hCD, 8'hC3, 8'hCA, 8'hCB, 8'hD7, 8'hE3, 8'hC5};
  always #5 clk = ~clk;
  pfm_pad_function_multiplexer i_pfm_pad_function_multiplexer (.i_sys_clk(clk), .i_reset_n(rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_deep_sleep_state(deep), .i_hibernate_state(hib), .i_general_out(gout),
    .i_general_oe(goe), .o_general_in(gin), .i_periph(per), .o_periph(pio), .i_pad_in(pin), .o_pad_out(pout),
    .o_pad_oe(poe), .o_pad_pull_en(pull));
  pfm_board i_pfm_board (.i_sys_clk(clk), .i_pad_out(pout), .i_pad_oe(poe), .i_ext_val(ext),
    .i_ext_en(ext_en), .o_pad_level(pin));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Expected drive and level of a pad, from slot and mode packed as one byte.
  function automatic logic [1:0] exp_pad(input logic [7:0] c);
    case (c)
      8'h00, 8'h20: return {goe[c[7:4]], gout[c[7:4]]};
      8'h18: return {1'b1, per.timer_pwm_out_3};
      8'h39: return {1'b1, per.timer_pwm_out_2};
      8'h32, 8'hD7: return {1'b1, per.audio_frame_sync};
      8'h49, 8'h63, 8'hCB: return {1'b1, per.serial0_transmit};
      8'h42, 8'hCD: return {1'b1, per.audio_bit_clock};
      8'h5A, 8'hC3: return {1'b1, per.serial1_request_to_send_n};
      8'h53, 8'hB5, 8'hCA: return {1'b1, per.serial0_request_to_send_n};
      8'h66, 8'h86: return {1'b1, per.serial1_transmit};
      8'hE3: return {1'b1, per.timer_pwm_out_5};
      default: return 2'b00;
    endcase
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h6673));
    rst_n <= 1'b0;
    repeat (19) @(posedge clk);
    chk(poe, 15'h0, "oe in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    ext <= 15'($urandom());
    settle();
    chk(poe[1], 1'b0, "pad21 oe");
    chk(pio.debug_test_clock, ext[1], "test clock in");
    wb(1'b0, pfm_pkg::PAD_OFS[1], '0);
    chk(q, 32'h1, "pad21 mode");
    wb(1'b0, pfm_pkg::PAD_OFS[2], '0);
    chk(q, 32'h1, "pad22 mode");
    wb(1'b1, 32'h4402E0F0, 32'hFFFFFFFF);
    wb(1'b0, 32'h4402E0F0, '0);
    chk(q, 32'h0, "unmapped");
    wb(1'b1, pfm_pkg::PAD_OFS[12], 32'hFFFFFFF5);
    wb(1'b0, pfm_pkg::PAD_OFS[12], '0);
    chk(q, 32'h5, "mode width");
    $display("test registers done");
    for (int r = 0; r < 3; r++) begin
      foreach (tab[i]) begin
        @(posedge clk);
        per <= pfm_pkg::pfm_periph_out_t'($urandom());
        gout <= 15'($urandom());
        goe <= 15'($urandom());
        wb(1'b1, pfm_pkg::PAD_OFS[tab[i][7:4]], {28'h0, tab[i][3:0]});
        settle();
        chk({poe[tab[i][7:4]], pout[tab[i][7:4]]}, exp_pad(tab[i]), "pad drive");
      end
    end
    $display("test output modes done");
    wb(1'b1, pfm_pkg::PAD_OFS[7], 32'h3);
    wb(1'b1, pfm_pkg::PAD_OFS[9], 32'h4);
    wb(1'b1, pfm_pkg::PAD_OFS[13], 32'hC);
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      ext <= 15'($urandom());
      settle();
      chk(pio.serial0_receive, ext[7], "pad47 receive");
      chk(pio.camera_data_bit2, ext[9], "pad49 camera");
      chk(pio.timer_capture_in_6, ext[13], "pad53 capture");
      chk(gin[13], ext[13], "general in");
    end
    $display("test input modes done");
    sv = $urandom();
    vv = $urandom();
    wb(1'b1, pfm_pkg::PAD_OFS[12], 32'hA);
    wb(1'b1, pfm_pkg::PAD_OFS[3], {28'h0, pfm_pkg::MODE_OSC});
    wb(1'b1, pfm_pkg::PAD_OFS[0], 32'h0);
    wb(1'b1, pfm_pkg::OFS_SLEEP_OE, sv);
    wb(1'b1, pfm_pkg::OFS_SLEEP_VAL, vv);
    wb(1'b1, pfm_pkg::OFS_PULL_EN, vv);
    @(posedge clk);
    per.serial0_request_to_send_n <= 1'b0;
    deep <= 1'b1;
    settle();
    chk({poe[12], pout[12]}, 2'b11, "sleep rts");
    chk({poe[3], pout[3]}, 2'b10, "sleep osc");
    chk({poe[0], pout[0]}, {sv[0], vv[0]}, "sleep general");
    chk(pull, vv[14:0], "pull enable");
    @(posedge clk);
    hib <= 1'b1;
    deep <= 1'b0;
    settle();
    chk({poe[3], pout[3]}, 2'b10, "hibernate osc");
    chk({poe[0], pout[0]}, {sv[0], vv[0]}, "hibernate general");
    @(posedge clk);
    hib <= 1'b0;
    $display("test sleep done");
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(poe, 15'h0, "oe in reset");
    chk(pull, 15'h0, "pull in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, pfm_pkg::PAD_OFS[12], '0);
    chk(q, {28'h0, pfm_pkg::MODE_NONE}, "mode after reset");
    $display("test mid reset done");
    stop_test();
  end
endmodule

// ### testbench/pfm_board.sv
module pfm_board (
  // Clock
  input wire logic        i_sys_clk,
  // Device side of the pads
  input wire logic [14:0] i_pad_out,
  input wire logic [14:0] i_pad_oe,
  // Board drivers
  input wire logic [14:0] i_ext_val,
  input wire logic [14:0] i_ext_en,
  output logic     [14:0] o_pad_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] idle_ff = '0;
  // A floating pad toggles so that no settled unknown can pass for a level.
  always_ff @(posedge i_sys_clk) begin
    idle_ff <= ~idle_ff;
  end
  assign o_pad_level = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext_en & i_ext_val) | (~i_pad_oe & ~i_ext_en & idle_ff);
endmodule

// ### testbench/pfm_chk.sv
module pfm_chk (
  // Clock, reset and bus
  input wire logic                     i_sys_clk,
  input wire logic                     i_reset_n,
  input wire logic                     i_wb_cyc,
  input wire logic                     i_wb_stb,
  input wire logic                     i_wb_we,
  input wire logic [31:0]              i_wb_adr,
  input wire logic [3:0]               i_wb_sel,
  input wire logic [31:0]              i_wb_dat,
  input wire logic [31:0]              o_wb_dat,
  input wire logic                     o_wb_ack,
  // Power state, peripherals and pads
  input wire logic                     i_deep_sleep_state,
  input wire logic                     i_hibernate_state,
  input wire pfm_pkg::pfm_periph_out_t i_periph,
  input wire logic [14:0]              o_pad_out,
  input wire logic [14:0]              o_pad_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  logic [3:0] m52_ff;
  logic [3:0] m23_ff;
  wire logic  wr_take = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0];
  wire logic  run = !i_deep_sleep_state && !i_hibernate_state;
  // Shadow of two mode registers so pad relations can be checked without the bodies.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      m52_ff <= pfm_pkg::MODE_NONE;
      m23_ff <= pfm_pkg::MODE_OSC;
    end else begin
      if (wr_take && i_wb_adr == pfm_pkg::PAD_OFS[12])
        m52_ff <= i_wb_dat[3:0];
      if (wr_take && i_wb_adr == pfm_pkg::PAD_OFS[3])
        m23_ff <= i_wb_dat[3:0];
    end
  end
  reset_float_a: assert property (!i_reset_n |-> o_pad_oe == '0 && !o_wb_ack)
    else $error("pad driven during reset");
  ack_pulse_a: assert property (disable iff (!i_reset_n) o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (disable iff (!i_reset_n) i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered");
  rdata_idle_a: assert property (disable iff (!i_reset_n) !o_wb_ack |-> o_wb_dat == '0)
    else $error("read data outside ack");
  p52_tx_a: assert property (disable iff (!i_reset_n) m52_ff == 4'hB && run
    |=> o_pad_oe[12] && o_pad_out[12] == $past(i_periph.serial0_transmit)) else $error("pad52 transmit wrong");
  p52_bad_a: assert property (disable iff (!i_reset_n) m52_ff == 4'h5 && run |=> !o_pad_oe[12])
    else $error("unassigned mode drives pad");
  sleep_rts_a: assert property (disable iff (!i_reset_n)
    m52_ff == 4'hA && i_deep_sleep_state |=> o_pad_oe[12] && o_pad_out[12]) else $error("sleep rts not high");
  osc_sleep_a: assert property (disable iff (!i_reset_n)
    m23_ff == pfm_pkg::MODE_OSC && i_deep_sleep_state |=> o_pad_oe[3] && !o_pad_out[3]) else $error("osc not low");
  hib_low_a: assert property (disable iff (!i_reset_n) i_hibernate_state |=> o_pad_oe[3] && !o_pad_out[3])
    else $error("pad23 not low in hibernate");
endmodule

bind pfm_pad_function_multiplexer pfm_chk i_pfm_chk (.i_sys_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we,
  .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_deep_sleep_state, .i_hibernate_state,
  .i_periph, .o_pad_out, .o_pad_oe);
